// ===== core/dtg_consts.svh
`ifndef DTG_CONSTS_SVH
`define DTG_CONSTS_SVH

// ring sizes
`define DTG_DIGITS 12
`define DTG_WORDS 10
`define DTG_SECTORS 5

// digit ring positions: DX first, sign next, then digits 1..10
`define DTG_POS_DX 0
`define DTG_POS_SIGN 1
`define DTG_POS_DIGIT(n) ((n) + 1)

// reset positions of the rings
`define DTG_RST_DIGIT 0
`define DTG_RST_WORD 0
`define DTG_RST_SECTOR 0

// timing
`define DTG_CLK_NS 40
`define DTG_QUARTER_NS 2000
`define DTG_DIGIT_NS 8000
`define DTG_QUARTER_CYC ((`DTG_QUARTER_NS + `DTG_CLK_NS - 1) / `DTG_CLK_NS)
`define DTG_DIGIT_CYC ((`DTG_DIGIT_NS + `DTG_CLK_NS - 1) / `DTG_CLK_NS)
// track considered lost after two digit intervals without a B edge
`define DTG_LOST_CYC (2 * `DTG_DIGIT_CYC)
`define DTG_LOST_W 10

`endif

// ===== core/dtg_pkg.sv
`include "dtg_consts.svh"

package dtg_pkg;

	// gray order along A, B, C, D
	typedef enum logic [1:0] {
		DTG_PH_A = 2'h0,
		DTG_PH_B = 2'h1,
		DTG_PH_C = 2'h3,
		DTG_PH_D = 2'h2
	} dtg_phase_e;

	typedef struct packed {
		logic home;
		logic sector;
		logic word;
		logic b;
		logic d;
		logic read_sample;
	} dtg_tracks_s;

	typedef struct packed {
		logic read_sample_strobe;
		logic write_sample_strobe;
		logic a_to_c_gate;
		logic c_to_a_gate;
		logic switching_digit_gate;
		logic sign_digit_gate;
		logic digits_1_4_gate;
		logic digits_5_10_gate;
		logic digits_5_9_gate;
		logic digits_5_8_gate;
		logic digits_1_10_gate;
		logic ten_and_1_4_gate;
		logic upper_digit_ten_gate;
		logic odd_digit_gate;
		logic even_digit_gate;
		logic odd_word_switch_to_first_gate;
		logic even_ten_to_odd_sign_gate;
		logic inverted_even_ten_to_odd_sign_gate;
		logic early_switching_gate;
		logic inverted_early_switching_gate;
		logic early_switching_lower_gate;
		logic early_switching_upper_gate;
		logic inverted_early_switching_lower_gate;
		logic inverted_early_switching_upper_gate;
		logic early_sign_gate;
		logic inverted_early_sign_gate;
		logic early_sign_lower_gate;
		logic early_sign_upper_gate;
		logic early_first_digit_gate;
		logic inverted_early_first_digit_gate;
		logic early_first_digit_lower_gate;
		logic early_first_digit_upper_gate;
		logic early_second_digit_gate;
		logic inverted_early_second_digit_gate;
		logic early_second_digit_lower_gate;
		logic even_word_gate;
		logic odd_word_gate;
		logic [`DTG_WORDS-1:0] word_gate;
		logic [`DTG_SECTORS-1:0] sector_gate;
	} dtg_gates_s;

endpackage : dtg_pkg

// ===== core/dtg_ring.sv
`timescale 1ns/1ps

module dtg_ring import dtg_pkg::*; #(
	parameter int N = 12,
	parameter int RST_POS = 0
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic step,
	input wire logic load,
	output logic [N-1:0] ring_nxt,
	output logic [N-1:0] ring_r
);

	typedef struct packed {
		logic [N-1:0] ring;
	} dtg_ring_st_s;

	localparam logic [N-1:0] RST_VEC = {{(N-1){1'b0}}, 1'b1} << RST_POS;

	dtg_ring_st_s st_r;
	dtg_ring_st_s st_nxt;

	always_comb begin
		st_nxt = st_r;
		// resync beats stepping so a home or word mark always wins
		if (load) begin
			st_nxt.ring = RST_VEC;
		end else if (step) begin
			st_nxt.ring = {st_r.ring[N-2:0], st_r.ring[N-1]};
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st_r <= '{ring: RST_VEC};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign ring_nxt = st_nxt.ring;
	assign ring_r = st_r.ring;

endmodule : dtg_ring

// ===== core/dtg_top.sv
`timescale 1ns/1ps

// Notes on behaviour
// (R1) read strobe follows its recorded track once per digit; samples readout data
// (R2) write strobe rises at B trailing edge, falls at D leading edge (C quarter)
// (R3) digit gates launched at A phase, valid from B to next A
// (R4) switching-digit and sign-digit gates, one digit each per word
// (R5) range gates 1-4, 5-10, 5-9, 5-8, 1-10, and ten plus 1-4
// (R6) digit-ten gate only in odd words
// (R7) odd-digit gate for X,1,3,5,7,9; even-digit gate for 0,2,4,6,8,10
// (R8) odd words: gate from C of switching digit to C of digit one
// (R9) gate from C of even-word ten to C of odd-word sign, plus inverse
// (R10) early gates launched at D of preceding digit, valid A to D
// (R11) early switching, sign, first, second gates, each with inverted companion
// (R12) early gates qualified by word parity; inverted early switching per parity
// (R13) sector gates span B of word-zero DX to A of next word-zero DX
// (R14) five sector gates from a ring, exactly one active
// (R15) ten word gates, each one word long, marking word position
// (R16) even-word gate in words 0,2,4,6,8; odd-word gate in 1,3,5,7,9
// (R17) A-to-C gate in first half of digit, C-to-A gate in second half
// (R18) sector, word, digit gates come from latch rings stepped by track pulses; word and sector rings step on the carry of the ring below
// (R19) digit split into four quarters A, B, C, D in order
// (R20) word is twelve digits: switching, sign, then one to ten
// (R21) even words are lower accumulator time, odd words upper
// (R22) word pulse resyncs digit ring, sector pulse word ring, home sector ring
// (R23) digit phase is a four-state counter stepped by B and D track edges

module dtg_top import dtg_pkg::*; #(
	parameter int DATA_W = 7
) (
	input wire logic mclk,
	input wire logic nrst,
	input dtg_tracks_s tracks,
	input wire logic [DATA_W-1:0] read_data_in,
	input wire logic [DATA_W-1:0] write_data_in,
	output dtg_gates_s gates,
	output logic [DATA_W-1:0] read_data_r,
	output logic [DATA_W-1:0] write_data_out,
	output logic track_lost
);

	typedef struct packed {
		dtg_phase_e phase;
		dtg_tracks_s prev;
		dtg_gates_s gates;
		logic [DATA_W-1:0] read_data;
		logic [DATA_W-1:0] write_data;
		logic [`DTG_LOST_W-1:0] lost_cnt;
		logic lost;
	} dtg_top_st_s;

	localparam logic [`DTG_LOST_W-1:0] LOST_CYC = `DTG_LOST_W'(`DTG_LOST_CYC);

	dtg_top_st_s st_r;
	dtg_top_st_s st_nxt;

	////////////////////////////////////////////////////////////////////////////////
	// track edges

	logic b_rise;
	logic b_fall;
	logic d_rise;
	logic d_fall;
	logic word_rise;
	logic sector_rise;
	logic home_rise;
	logic rsp_rise;

	always_comb begin
		b_rise = tracks.b & ~st_r.prev.b;
		b_fall = ~tracks.b & st_r.prev.b;
		d_rise = tracks.d & ~st_r.prev.d;
		d_fall = ~tracks.d & st_r.prev.d;
		word_rise = tracks.word & ~st_r.prev.word;
		sector_rise = tracks.sector & ~st_r.prev.sector;
		home_rise = tracks.home & ~st_r.prev.home;
		rsp_rise = tracks.read_sample & ~st_r.prev.read_sample;
	end

	////////////////////////////////////////////////////////////////////////////////
	// rings

	logic [`DTG_DIGITS-1:0] dig_nxt;
	logic [`DTG_DIGITS-1:0] dig_r;
	logic [`DTG_WORDS-1:0] wrd_nxt;
	logic [`DTG_WORDS-1:0] wrd_r;
	logic [`DTG_SECTORS-1:0] sec_nxt;
	logic [`DTG_SECTORS-1:0] sec_r;
	logic word_step;
	logic sector_step;

	// (R18) digit ring steps at D trailing edge, which opens the next A quarter
	// (R22) word pulse forces the switching digit
	dtg_ring #(
		.N(`DTG_DIGITS),
		.RST_POS(`DTG_RST_DIGIT)
	) u_digit_ring (
		.mclk(mclk),
		.nrst(nrst),
		.step(d_fall),
		.load(word_rise),
		.ring_nxt(dig_nxt),
		.ring_r(dig_r)
	);

	// (R20) a word closes when the digit ring re-enters the switching digit
	assign word_step = dig_nxt[`DTG_POS_DX] & ~dig_r[`DTG_POS_DX];
	assign sector_step = wrd_nxt[0] & ~wrd_r[0];

	// (R22) sector pulse forces word zero
	dtg_ring #(
		.N(`DTG_WORDS),
		.RST_POS(`DTG_RST_WORD)
	) u_word_ring (
		.mclk(mclk),
		.nrst(nrst),
		.step(word_step),
		.load(sector_rise),
		.ring_nxt(wrd_nxt),
		.ring_r(wrd_r)
	);

	// (R22) home pulse forces sector zero
	dtg_ring #(
		.N(`DTG_SECTORS),
		.RST_POS(`DTG_RST_SECTOR)
	) u_sector_ring (
		.mclk(mclk),
		.nrst(nrst),
		.step(sector_step),
		.load(home_rise),
		.ring_nxt(sec_nxt),
		.ring_r(sec_r)
	);

	////////////////////////////////////////////////////////////////////////////////
	// digit decode

	logic at_dx;
	logic at_sign;
	logic at_ten;
	logic in_1_4;
	logic in_5_8;
	logic in_5_9;
	logic in_5_10;
	logic in_1_10;
	logic odd_pos;
	logic even_pos;

	// decoded from the next ring value so every digit gate moves in the same cycle
	always_comb begin
		at_dx = dig_nxt[`DTG_POS_DX];
		at_sign = dig_nxt[`DTG_POS_SIGN];
		at_ten = dig_nxt[`DTG_POS_DIGIT(10)];
		// (R5) digit ranges
		in_1_4 = |dig_nxt[`DTG_POS_DIGIT(4):`DTG_POS_DIGIT(1)];
		in_5_8 = |dig_nxt[`DTG_POS_DIGIT(8):`DTG_POS_DIGIT(5)];
		in_5_9 = |dig_nxt[`DTG_POS_DIGIT(9):`DTG_POS_DIGIT(5)];
		in_5_10 = |dig_nxt[`DTG_POS_DIGIT(10):`DTG_POS_DIGIT(5)];
		in_1_10 = |dig_nxt[`DTG_POS_DIGIT(10):`DTG_POS_DIGIT(1)];
		// (R7) the switching digit counts as odd, the sign digit as even
		odd_pos = |{at_dx, dig_nxt[`DTG_POS_DIGIT(1)],
			dig_nxt[`DTG_POS_DIGIT(3)], dig_nxt[`DTG_POS_DIGIT(5)],
			dig_nxt[`DTG_POS_DIGIT(7)], dig_nxt[`DTG_POS_DIGIT(9)]};
		even_pos = |{at_sign, dig_nxt[`DTG_POS_DIGIT(2)],
			dig_nxt[`DTG_POS_DIGIT(4)], dig_nxt[`DTG_POS_DIGIT(6)],
			dig_nxt[`DTG_POS_DIGIT(8)], at_ten};
	end

	////////////////////////////////////////////////////////////////////////////////
	// phase, gates and strobes

	logic odd_w;
	logic odd_early;
	logic first_half;
	logic [`DTG_DIGITS-1:0] early;
	dtg_phase_e ph;

	always_comb begin
		st_nxt = st_r;
		st_nxt.prev = tracks;

		// (R23) phase stepped by B and D track edges
		// (R19) quarters follow A, B, C, D
		case (st_r.phase)
			DTG_PH_A: begin
				if (b_rise) begin
					st_nxt.phase = DTG_PH_B;
				end
			end
			DTG_PH_B: begin
				if (b_fall) begin
					st_nxt.phase = DTG_PH_C;
				end
			end
			DTG_PH_C: begin
				if (d_rise) begin
					st_nxt.phase = DTG_PH_D;
				end
			end
			DTG_PH_D: begin
				if (d_fall) begin
					st_nxt.phase = DTG_PH_A;
				end
			end
			default: begin
				st_nxt.phase = DTG_PH_A;
			end
		endcase
		// word mark sits at A time, so it also realigns the phase
		if (word_rise) begin
			st_nxt.phase = DTG_PH_A;
		end
		ph = st_nxt.phase;
		first_half = (ph == DTG_PH_A) || (ph == DTG_PH_B);

		// (R21) odd position in the word ring means upper accumulator time
		odd_w = |{wrd_nxt[9], wrd_nxt[7], wrd_nxt[5], wrd_nxt[3], wrd_nxt[1]};

		// (R10) early ring looks one digit ahead during the D quarter
		if (ph == DTG_PH_D) begin
			early = {dig_nxt[`DTG_DIGITS-2:0], dig_nxt[`DTG_DIGITS-1]};
		end else begin
			early = dig_nxt;
		end
		// early switching digit belongs to the coming word, of opposite parity
		odd_early = (ph == DTG_PH_D && dig_nxt[`DTG_POS_DIGIT(10)]) ? ~odd_w : odd_w;

		// (R1) strobe copies its recorded track
		st_nxt.gates.read_sample_strobe = tracks.read_sample;
		if (rsp_rise) begin
			st_nxt.read_data = read_data_in;
		end
		// (R2) C quarter opened by B trailing edge, closed by D leading edge
		st_nxt.gates.write_sample_strobe = (ph == DTG_PH_C);
		st_nxt.write_data = (ph == DTG_PH_C) ? write_data_in : '0;

		// (R17) half-digit phase gates
		st_nxt.gates.a_to_c_gate = first_half;
		st_nxt.gates.c_to_a_gate = ~first_half;

		// (R3) digit gates switch with the ring at A
		// (R4) switching and sign digits
		st_nxt.gates.switching_digit_gate = at_dx;
		st_nxt.gates.sign_digit_gate = at_sign;
		// (R5) range gates
		st_nxt.gates.digits_1_4_gate = in_1_4;
		st_nxt.gates.digits_5_10_gate = in_5_10;
		st_nxt.gates.digits_5_9_gate = in_5_9;
		st_nxt.gates.digits_5_8_gate = in_5_8;
		st_nxt.gates.digits_1_10_gate = in_1_10;
		st_nxt.gates.ten_and_1_4_gate = at_ten | in_1_4;
		// (R6) digit ten, odd words only
		st_nxt.gates.upper_digit_ten_gate = at_ten & odd_w;
		// (R7) odd positions X,1,3,5,7,9 and even positions 0,2,4,6,8,10
		st_nxt.gates.odd_digit_gate = odd_pos;
		st_nxt.gates.even_digit_gate = even_pos;

		// (R8) C of DX through C of digit one, odd words
		st_nxt.gates.odd_word_switch_to_first_gate = odd_w & (
			(dig_nxt[`DTG_POS_DX] & ~first_half)
			| dig_nxt[`DTG_POS_SIGN]
			| (dig_nxt[`DTG_POS_DIGIT(1)] & first_half));
		// (R9) C of even-word ten through C of odd-word sign, and its inverse
		st_nxt.gates.even_ten_to_odd_sign_gate =
			(~odd_w & dig_nxt[`DTG_POS_DIGIT(10)] & ~first_half)
			| (odd_w & dig_nxt[`DTG_POS_DX])
			| (odd_w & dig_nxt[`DTG_POS_SIGN] & first_half);
		st_nxt.gates.inverted_even_ten_to_odd_sign_gate =
			~st_nxt.gates.even_ten_to_odd_sign_gate;

		// (R11) early gates and inverted companions
		st_nxt.gates.early_switching_gate = early[`DTG_POS_DX];
		st_nxt.gates.inverted_early_switching_gate = ~early[`DTG_POS_DX];
		st_nxt.gates.early_sign_gate = early[`DTG_POS_SIGN];
		st_nxt.gates.inverted_early_sign_gate = ~early[`DTG_POS_SIGN];
		st_nxt.gates.early_first_digit_gate = early[`DTG_POS_DIGIT(1)];
		st_nxt.gates.inverted_early_first_digit_gate = ~early[`DTG_POS_DIGIT(1)];
		st_nxt.gates.early_second_digit_gate = early[`DTG_POS_DIGIT(2)];
		st_nxt.gates.inverted_early_second_digit_gate = ~early[`DTG_POS_DIGIT(2)];
		// (R12) parity-qualified early gates
		st_nxt.gates.early_switching_lower_gate = early[`DTG_POS_DX] & ~odd_early;
		st_nxt.gates.early_switching_upper_gate = early[`DTG_POS_DX] & odd_early;
		st_nxt.gates.inverted_early_switching_lower_gate = ~(early[`DTG_POS_DX] & ~odd_early);
		st_nxt.gates.inverted_early_switching_upper_gate = ~(early[`DTG_POS_DX] & odd_early);
		st_nxt.gates.early_sign_lower_gate = early[`DTG_POS_SIGN] & ~odd_w;
		st_nxt.gates.early_sign_upper_gate = early[`DTG_POS_SIGN] & odd_w;
		st_nxt.gates.early_first_digit_lower_gate = early[`DTG_POS_DIGIT(1)] & ~odd_w;
		st_nxt.gates.early_first_digit_upper_gate = early[`DTG_POS_DIGIT(1)] & odd_w;
		st_nxt.gates.early_second_digit_lower_gate = early[`DTG_POS_DIGIT(2)] & ~odd_w;

		// (R15) word gates, one word each
		st_nxt.gates.word_gate = wrd_nxt;
		// (R16) word parity gates
		st_nxt.gates.even_word_gate = ~odd_w;
		st_nxt.gates.odd_word_gate = odd_w;
		// (R13) sector gates switch with word zero's switching digit
		// (R14) one-hot, so exactly one sector is active
		st_nxt.gates.sector_gate = sec_nxt;

		// no B edge for two digits means the drum or its track amplifier stopped
		if (b_rise) begin
			st_nxt.lost_cnt = '0;
			st_nxt.lost = 1'b0;
		end else if (st_r.lost_cnt == LOST_CYC) begin
			st_nxt.lost = 1'b1;
		end else begin
			st_nxt.lost_cnt = st_r.lost_cnt + `DTG_LOST_W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st_r <= '0;
			st_r.phase <= DTG_PH_A;
			st_r.gates.switching_digit_gate <= 1'b1;
			st_r.gates.odd_digit_gate <= 1'b1;
			st_r.gates.a_to_c_gate <= 1'b1;
			st_r.gates.early_switching_gate <= 1'b1;
			st_r.gates.early_switching_lower_gate <= 1'b1;
			st_r.gates.inverted_early_switching_upper_gate <= 1'b1;
			st_r.gates.inverted_early_sign_gate <= 1'b1;
			st_r.gates.inverted_early_first_digit_gate <= 1'b1;
			st_r.gates.inverted_early_second_digit_gate <= 1'b1;
			st_r.gates.inverted_even_ten_to_odd_sign_gate <= 1'b1;
			st_r.gates.even_word_gate <= 1'b1;
			st_r.gates.word_gate <= `DTG_WORDS'(1);
			st_r.gates.sector_gate <= `DTG_SECTORS'(1);
		end else begin
			st_r <= st_nxt;
		end
	end

	assign gates = st_r.gates;
	assign read_data_r = st_r.read_data;
	assign write_data_out = st_r.write_data;
	assign track_lost = st_r.lost;

endmodule : dtg_top

// ===== dv/dtg_assertions.sv
`timescale 1ns/1ps

module dtg_assertions import dtg_pkg::*; #(
	parameter int DATA_W = 7
) (
	input wire logic mclk,
	input wire logic nrst,
	input dtg_tracks_s tracks,
	input wire logic [DATA_W-1:0] read_data_in,
	input wire logic [DATA_W-1:0] write_data_in,
	input dtg_gates_s gates,
	input wire logic [DATA_W-1:0] read_data_r,
	input wire logic [DATA_W-1:0] write_data_out,
	input wire logic track_lost
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!nrst);
	logic [9:0] idle_r;
	logic b_prev_r;
	////////////////////////////////////////
	// cycles since the last rising b; saturates so it never wraps back to quiet
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			idle_r <= 10'h000;
			b_prev_r <= 1'b0;
		end else begin
			b_prev_r <= tracks.b;
			idle_r <= (tracks.b && !b_prev_r) ? 10'h000 : idle_r + {9'h000, idle_r != 10'h3FF};
		end
	end
	////////////////////////////////////////
	a_read_strobe: assert property ($rose(tracks.read_sample) |=>
		gates.read_sample_strobe && read_data_r == $past(read_data_in))
		else $error("read strobe or capture wrong");
	a_write_on: assert property ($fell(tracks.b) |=>
		gates.write_sample_strobe && gates.c_to_a_gate) else $error("write strobe late");
	a_write_off: assert property ($rose(tracks.d) |=> !gates.write_sample_strobe)
		else $error("write strobe stuck");
	a_sector_onehot: assert property ($onehot(gates.sector_gate))
		else $error("sector gates not one-hot");
	a_word_onehot: assert property ($onehot(gates.word_gate))
		else $error("word gates not one-hot");
	a_word_parity: assert property (gates.even_word_gate == |(gates.word_gate & 10'h155)
		&& gates.odd_word_gate == !gates.even_word_gate) else $error("word parity wrong");
	a_upper_ten: assert property (gates.upper_digit_ten_gate |->
		gates.odd_word_gate && gates.digits_5_10_gate && !gates.digits_5_9_gate)
		else $error("digit ten gate outside odd word");
	a_word_resync: assert property ($rose(tracks.word) |=> gates.switching_digit_gate)
		else $error("word pulse did not resync");
	a_home_resync: assert property ($rose(tracks.home) |=>
		gates.sector_gate[0] && gates.word_gate[0]) else $error("home did not resync");
	a_early_lead: assert property ($rose(tracks.d) && gates.sign_digit_gate |=>
		gates.early_first_digit_gate && !gates.inverted_early_first_digit_gate)
		else $error("early gate did not lead");
	a_lost_low: assert property (idle_r > 10'h002 && idle_r < 10'h186 |-> !track_lost)
		else $error("track lost too early");
	a_lost_high: assert property (idle_r > 10'h19A |-> track_lost)
		else $error("track lost missing");
	c_sector_four: cover property ($rose(gates.sector_gate[4]));
	c_lost: cover property ($rose(track_lost));
	c_upper_ten: cover property ($rose(gates.upper_digit_ten_gate));
endmodule : dtg_assertions

bind dtg_top dtg_assertions #(.DATA_W(DATA_W)) u_chk (.mclk(mclk), .nrst(nrst),
	.tracks(tracks), .read_data_in(read_data_in), .write_data_in(write_data_in),
	.gates(gates), .read_data_r(read_data_r), .write_data_out(write_data_out),
	.track_lost(track_lost));

// ===== dv/dtg_track_model.sv
`timescale 1ns/1ps

module dtg_track_model import dtg_pkg::*; #(
	parameter int QC = 8
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic run,
	output dtg_tracks_s tracks,
	output int c,
	output int q,
	output int d,
	output int w,
	output int s
);
	// quarters A..D, twelve digits a word, ten words, five sectors
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			c <= 0;
			q <= 0;
			d <= 0;
			w <= 0;
			s <= 0;
		end else if (run) begin
			c <= #1 (c + 1) % QC;
			if (c == QC - 1) begin
				q <= #1 (q + 1) % 4;
				if (q == 3) begin
					d <= #1 (d + 1) % 12;
					if (d == 11) begin
						w <= #1 (w + 1) % 10;
						if (w == 9)
							s <= #1 (s + 1) % 5;
					end
				end
			end
		end
	end
	////////////////////////////////////////
	// a stalled drum leaves every track low
	always_comb begin
		// recorded b and d quarters, sample pulse in the first half of b
		tracks.b = run && q == 1;
		tracks.d = run && q == 3;
		tracks.read_sample = run && q == 1 && c < QC / 2;
		// word pulse at A of the switching digit, sector and home ride on it
		tracks.word = run && q == 0 && d == 0 && c < QC / 2;
		tracks.sector = tracks.word && w == 0;
		tracks.home = tracks.sector && s == 0;
	end
endmodule : dtg_track_model

// ===== dv/dtg_tb_top.sv
`timescale 1ns/1ps

module dtg_tb_top import dtg_pkg::*;;
	localparam int QC = 8;
	logic mclk;
	logic nrst;
	logic run;
	logic [6:0] rdat;
	logic [6:0] wdat;
	logic [6:0] rd_r;
	logic [6:0] wr_out;
	logic lost;
	dtg_tracks_s tracks;
	dtg_gates_s gates;
	int c, q, d, w, s;
	int seed = 13525;
	int err_total = 0;
	int tests_run = 0;
	// read data expected from the B capture just made, queued when the sample pulse is up
	logic [6:0] rd_q[$];

	dtg_track_model #(.QC(QC)) u_trk (.mclk(mclk), .nrst(nrst), .run(run), .tracks(tracks),
		.c(c), .q(q), .d(d), .w(w), .s(s));
	dtg_top #(.DATA_W(7)) u_dut (.mclk(mclk), .nrst(nrst), .tracks(tracks),
		.read_data_in(rdat), .write_data_in(wdat), .gates(gates), .read_data_r(rd_r),
		.write_data_out(wr_out), .track_lost(lost));

	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	////////////////////////////////////////
	// gates expected from phase, digit, word and sector positions
	function automatic dtg_gates_s exp_g(int q, int d, int w, int s);
		int n;
		int ed;
		logic o;
		logic cd;
		logic eo;
		logic r9;
		n = d - 1;
		o = w % 2 == 1;
		cd = q >= 2;
		ed = q == 3 ? (d + 1) % 12 : d;
		eo = (q == 3 && d == 11 ? (w + 1) % 10 : w) % 2 == 1;
		r9 = (!o && n == 10 && cd) || (o && (d == 0 || (d == 1 && !cd)));
		return dtg_gates_s'{q == 1, q == 2, !cd, cd, d == 0, d == 1, n >= 1 && n <= 4, n >= 5,
			n >= 5 && n <= 9, n >= 5 && n <= 8, n >= 1, n == 10 || (n >= 1 && n <= 4),
			n == 10 && o, d == 0 || n % 2 == 1, d > 0 && n % 2 == 0,
			o && ((d == 0 && cd) || d == 1 || (d == 2 && !cd)), r9, !r9,
			ed == 0, ed != 0, ed == 0 && !eo, ed == 0 && eo, !(ed == 0 && !eo), !(ed == 0 && eo),
			ed == 1, ed != 1, ed == 1 && !eo, ed == 1 && eo, ed == 2, ed != 2, ed == 2 && !eo,
			ed == 2 && eo, ed == 3, ed != 3, ed == 3 && !eo, !o, o, 10'(1 << w), 5'(1 << s)};
	endfunction : exp_g

	task automatic cmp(input logic ok, input string m);
		tests_run++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask : cmp

	task automatic chk_reset();
		cmp(gates === exp_g(0, 0, 0, 0), "reset gates");
		cmp(rd_r === 7'h00 && wr_out === 7'h00 && lost === 1'b0, "reset outputs");
	endtask : chk_reset

	task automatic done(input string t);
		$display("test %s finished", t);
	endtask : done

	task automatic report_and_stop();
		$display("comparisons %0d mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop
	////////////////////////////////////////
	// new data each quarter; read data moves only at A so the B capture is steady
	always @(posedge mclk) begin
		if (nrst && run && c == QC - 1) begin
			wdat <= #1 7'($random(seed));
			if (q == 3)
				rdat <= #1 7'($random(seed));
		end
	end

	// mid-quarter compare, clear of the one-cycle answer latency
	always @(negedge mclk) begin
		if (nrst && run && c == 2) begin
			cmp(gates === exp_g(q, d, w, s), "gates");
			cmp(wr_out === (q == 2 ? wdat : 7'h00), "write data");
			if (q == 1)
				rd_q.push_back(rdat);
			if (q == 2)
				cmp(rd_q.size() > 0 && rd_r === rd_q.pop_front(), "read data");
		end
	end

	initial begin
		#(40 * 40000);
		err_total++;
		$display("[FAIL] %0t watchdog", $time);
		report_and_stop();
	end

	initial begin
		nrst = 1'b0;
		run = 1'b1;
		rdat = 7'h00;
		wdat = 7'h00;
		repeat (5) @(posedge mclk);
		#1 chk_reset();
		nrst = 1'b1;
		done("reset");
		// one full revolution and one more sector
		repeat (23100) @(posedge mclk);
		done("revolution");
		while (!(q == 0 && c == 1 && d == 5))
			@(posedge mclk);
		#1 run = 1'b0;
		repeat (360) @(posedge mclk);
		#2 cmp(lost === 1'b0, "lost too early");
		repeat (50) @(posedge mclk);
		#2 cmp(lost === 1'b1, "lost missing");
		@(posedge mclk);
		#1 run = 1'b1;
		repeat (2000) @(posedge mclk);
		done("stall");
		#1 nrst = 1'b0;
		repeat (2) @(posedge mclk);
		rd_q.delete();
		#1 chk_reset();
		nrst = 1'b1;
		repeat (1000) @(posedge mclk);
		done("second reset");
		report_and_stop();
	end
endmodule : dtg_tb_top
